/* phase_res_pkg.sv */
// shared types and constants for the phase resistance decoder
`default_nettype none
package phase_res_pkg;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned EXPONENT_W = 3;
  localparam int unsigned MANTISSA_W = 4;
  localparam int unsigned DIG_W = 11;
  localparam int unsigned MICRO_W = 25;
  localparam int unsigned WEIGHT_W = 14;
  // one lsb is 9.67 milliohm, kept as hundredths of a milliohm
  localparam int unsigned LSB_CENTI_MILLIOHM = 967;
  localparam logic [WEIGHT_W-1:0] LSB_MICRO_OHM = WEIGHT_W'(LSB_CENTI_MILLIOHM * 10);
  localparam logic [CODE_W-1:0] CODE_ALL_ONES = 7'h7f;
  localparam logic [DIG_W-1:0] DIG_MAX = 11'h780;
  localparam logic [DIG_W-1:0] DIG_MIN_SUPPORTED = 11'h003;
  localparam logic [DIG_W-1:0] DIG_RESET = 11'h000;
  localparam logic [MICRO_W-1:0] MICRO_RESET = 25'h0000000;
  localparam int unsigned MANTISSA_TOP_BIT = 3;

  typedef struct packed {
    logic [EXPONENT_W-1:0] exponent;
    logic [MANTISSA_W-1:0] mantissa;
  } phase_res_code_s;

  typedef struct packed {
    logic [DIG_W-1:0] dig;
    logic [MICRO_W-1:0] microOhm;
    logic belowMinimum;
    logic canonical;
  } phase_res_result_s;
endpackage
`default_nettype wire

/* phase_res_shifter.sv */
// mantissa shifted left by exponent, purely combinational
`default_nettype none
module phase_res_shifter (
  // encoded code
  input wire phase_res_pkg::phase_res_code_s phaseResCode,
  // decoded integer
  output logic [phase_res_pkg::DIG_W-1:0] phaseResDig
);
  wire [phase_res_pkg::DIG_W-1:0] mantissaWide;

  // eleven bits hold 15 << 7 with no loss
  assign mantissaWide = phase_res_pkg::DIG_W'(phaseResCode.mantissa);
  assign phaseResDig = mantissaWide << phaseResCode.exponent;
endmodule
`default_nettype wire

/* phase_res_decoder.sv */
// registered decoder of the seven-bit phase resistance code
// Behaviour
// - code is seven bits: upper three exponent, lower four mantissa
// - decoded integer is mantissa shifted left by exponent
// - one integer unit weighs 9.67 milliohm phase-to-centre resistance
// - all-ones code decodes to 1920, about 18.57 ohm
// - code is exactly seven bits, read as unsigned
`default_nettype none
module phase_res_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // code from the configuration store
  input wire logic [phase_res_pkg::CODE_W-1:0] phaseResCode,
  // decoded results
  output logic [phase_res_pkg::DIG_W-1:0] phaseResDig,
  output logic [phase_res_pkg::MICRO_W-1:0] phaseToCentreResistance,
  output logic belowMinimum,
  output logic canonicalCode,
  output logic decodeUpdate
);
  phase_res_pkg::phase_res_code_s codeFields;
  phase_res_pkg::phase_res_result_s result_reg;
  phase_res_pkg::phase_res_result_s result_next;
  logic update_reg;
  logic update_next;
  logic [phase_res_pkg::DIG_W-1:0] shiftedDig;
  wire [phase_res_pkg::MICRO_W-1:0] digWide;
  wire [phase_res_pkg::MICRO_W-1:0] scaledMicro;

  // field split; code is unsigned so no sign handling
  assign codeFields = phase_res_pkg::phase_res_code_s'(phaseResCode);

  phase_res_shifter shifter (
    .phaseResCode(codeFields),
    .phaseResDig(shiftedDig)
  );

  // scaling uses the registered integer: one extra cycle, but no long path
  assign digWide = phase_res_pkg::MICRO_W'(result_reg.dig);
  assign scaledMicro = phase_res_pkg::MICRO_W'(digWide * phase_res_pkg::LSB_MICRO_OHM);

  always_comb begin
    result_next.dig = shiftedDig;
    result_next.microOhm = scaledMicro;
    // status only: a code under the minimum still decodes as written
    result_next.belowMinimum = shiftedDig < phase_res_pkg::DIG_MIN_SUPPORTED;
    // table form: exponent zero or mantissa top bit set
    result_next.canonical = (codeFields.exponent == '0) ||
                            codeFields.mantissa[phase_res_pkg::MANTISSA_TOP_BIT];
    update_next = shiftedDig != result_reg.dig;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      result_reg.dig <= phase_res_pkg::DIG_RESET;
      result_reg.microOhm <= phase_res_pkg::MICRO_RESET;
      result_reg.belowMinimum <= 1'b0;
      result_reg.canonical <= 1'b0;
      update_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
      update_reg <= update_next;
    end
  end

  assign phaseResDig = result_reg.dig;
  assign phaseToCentreResistance = result_reg.microOhm;
  assign belowMinimum = result_reg.belowMinimum;
  assign canonicalCode = result_reg.canonical;
  assign decodeUpdate = update_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // a code is seen on one edge, its integer on the next edge and its scaled value one edge after that
  sequence seq_code_all_ones;
    phaseResCode == phase_res_pkg::CODE_ALL_ONES;
  endsequence

  sequence seq_dig_max;
    phaseResDig == phase_res_pkg::DIG_MAX;
  endsequence

  sequence seq_scaled_max;
    phaseToCentreResistance == 25'(phase_res_pkg::DIG_MAX * phase_res_pkg::LSB_MICRO_OHM);
  endsequence

  // smallest supported value is also a plain mantissa with exponent zero
  sequence seq_code_min;
    phaseResCode == 7'(phase_res_pkg::DIG_MIN_SUPPORTED);
  endsequence

  sequence seq_dig_min;
    phaseResDig == phase_res_pkg::DIG_MIN_SUPPORTED && !belowMinimum;
  endsequence

  sequence seq_in_reset;
    !rst_b;
  endsequence

  sequence seq_outputs_clear;
    phaseResDig == phase_res_pkg::DIG_RESET &&
      phaseToCentreResistance == phase_res_pkg::MICRO_RESET &&
      !belowMinimum && !canonicalCode && !decodeUpdate;
  endsequence

  sequence seq_code_settled;
    rst_b ##1 $stable(phaseResCode);
  endsequence

  property p_all_ones_max;
    seq_code_all_ones ##1 rst_b |-> seq_dig_max ##1 seq_scaled_max;
  endproperty

  property p_max_unique;
    rst_b ##1 seq_dig_max |-> $past(phaseResCode) == phase_res_pkg::CODE_ALL_ONES;
  endproperty

  property p_shift_decode;
    $past(rst_b) |->
      phaseResDig == (11'($past(codeFields.mantissa)) << $past(codeFields.exponent));
  endproperty

  property p_exponent_zero;
    codeFields.exponent == 3'h0 ##1 rst_b |-> phaseResDig == 11'($past(codeFields.mantissa));
  endproperty

  property p_top_exponent;
    codeFields.exponent == 3'h7 ##1 rst_b |-> phaseResDig[6:0] == 7'h00;
  endproperty

  property p_unsigned_zero;
    codeFields.mantissa == 4'h0 ##1 rst_b |-> phaseResDig == 11'h000;
  endproperty

  property p_weight_scale;
    $past(rst_b, 2) && $past(rst_b) |->
      phaseToCentreResistance == 25'($past(phaseResDig) * phase_res_pkg::LSB_MICRO_OHM);
  endproperty

  // a wider reference shows that eleven bits never drop a top bit
  property p_width_bound;
    $past(rst_b) |-> phaseResDig <= phase_res_pkg::DIG_MAX &&
      32'(phaseResDig) == (32'($past(codeFields.mantissa)) << $past(codeFields.exponent));
  endproperty

  // reset must win over any code, so these two are never disabled
  property p_reset_clear;
    disable iff (1'b0) seq_in_reset |=> seq_outputs_clear;
  endproperty

  property p_scaled_lag;
    disable iff (1'b0) seq_in_reset ##1 rst_b |=>
      phaseToCentreResistance == phase_res_pkg::MICRO_RESET;
  endproperty

  property p_below_flag;
    $past(rst_b) |-> belowMinimum == (phaseResDig < phase_res_pkg::DIG_MIN_SUPPORTED);
  endproperty

  property p_min_supported;
    seq_code_min ##1 rst_b |-> seq_dig_min;
  endproperty

  property p_zero_below;
    codeFields.mantissa == 4'h0 ##1 rst_b |-> belowMinimum;
  endproperty

  property p_canonical_flag;
    $past(rst_b) |-> canonicalCode == ($past(codeFields.exponent) == 3'h0 ||
      $past(codeFields.mantissa[phase_res_pkg::MANTISSA_TOP_BIT]));
  endproperty

  property p_update_pulse;
    $past(rst_b) |-> decodeUpdate == (phaseResDig != $past(phaseResDig));
  endproperty

  // a held code must not wake the consumer a second time
  property p_update_quiet;
    seq_code_settled |=> !decodeUpdate && $stable(phaseResDig);
  endproperty

  a_all_ones_max: assert property (p_all_ones_max)
    else $error("all-ones code did not give 1920 and its scaled value");

  a_max_unique: assert property (p_max_unique)
    else $error("largest integer came from a code other than all ones");

  a_shift_decode: assert property (p_shift_decode)
    else $error("decoded integer is not mantissa shifted by exponent");

  a_exponent_zero: assert property (p_exponent_zero)
    else $error("exponent zero must pass the mantissa unchanged");

  a_top_exponent: assert property (p_top_exponent)
    else $error("largest exponent must leave the seven low bits clear");

  a_unsigned_zero: assert property (p_unsigned_zero)
    else $error("zero mantissa must decode to zero for any exponent");

  a_weight_scale: assert property (p_weight_scale)
    else $error("scaled resistance is not the integer times 9670 microohm");

  a_width_bound: assert property (p_width_bound)
    else $error("decoded integer above 1920 or cut at eleven bits");

  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not zero after a reset cycle");

  a_scaled_lag: assert property (p_scaled_lag)
    else $error("scaled value not zero on the first cycle after reset");

  a_below_flag: assert property (p_below_flag)
    else $error("minimum flag disagrees with decoded integer");

  a_min_supported: assert property (p_min_supported)
    else $error("smallest supported code is flagged or misdecoded");

  a_zero_below: assert property (p_zero_below)
    else $error("zero mantissa not flagged as below the minimum");

  a_canonical_flag: assert property (p_canonical_flag)
    else $error("table form flag disagrees with the code fields");

  a_update_pulse: assert property (p_update_pulse)
    else $error("update pulse does not mark a change of the integer");

  a_update_quiet: assert property (p_update_quiet)
    else $error("update pulse raised for a code that did not change");
endmodule
`default_nettype wire

/* phase_res_consumer.sv */
// stand-in for the control core that latches each fresh resistance value
`default_nettype none
module phase_res_consumer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // decoder results
  input wire logic [phase_res_pkg::DIG_W-1:0] dig,
  input wire logic update,
  // value in use by the control loop
  output logic [phase_res_pkg::DIG_W-1:0] heldDig
);
  timeunit 1ns;
  timeprecision 1ns;
  // takes the value only on the pulse, so a missing pulse leaves it stale
  always_ff @(posedge clk) begin
    if (!rst_b) heldDig <= 11'h000;
    else if (update) heldDig <= dig;
  end
endmodule
`default_nettype wire

/* phase_res_decoder_tb_top.sv */
// self-checking bench for the phase resistance decoder
`default_nettype none
module phase_res_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [phase_res_pkg::CODE_W-1:0] code = 7'h7f;
  logic [phase_res_pkg::DIG_W-1:0] dig, held;
  logic [phase_res_pkg::MICRO_W-1:0] micro;
  logic belowMin, canon, upd;
  int miscompares = 0;
  int samples_checked = 0;
  phase_res_decoder dut_u (.clk(clk), .rst_b(rst_b), .phaseResCode(code), .phaseResDig(dig),
    .phaseToCentreResistance(micro), .belowMinimum(belowMin), .canonicalCode(canon),
    .decodeUpdate(upd));
  phase_res_consumer core_u (.clk(clk), .rst_b(rst_b), .dig(dig), .update(upd), .heldDig(held));
  initial begin
    forever #20 clk = ~clk;
  end
  // expected value built independently of the design
  function automatic logic [31:0] expDig(input int c);
    logic [6:0] k;
    k = 7'(c);
    return 32'(11'(k[3:0]) << k[6:4]);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_reset();
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk(32'(dig), 32'h0);
    chk(32'(micro), 32'h0);
    chk(32'(upd), 32'h0);
    chk(32'(belowMin), 32'h0);
    chk(32'(canon), 32'h0);
    @(posedge clk) rst_b <= 1'b1;
    $display("test_reset done");
  endtask
  // back-to-back sweep of every code, one new code per cycle
  task automatic test_sweep();
    logic [6:0] prev;
    for (int i = 0; i < 128; i++) begin
      @(posedge clk) code <= 7'(i);
      @(negedge clk);
      prev = 7'(i - 1);
      if (i > 1) begin
        chk(32'(dig), expDig(i - 1));
        chk(32'(belowMin), 32'(expDig(i - 1) < 32'h3));
        chk(32'(micro), expDig(i - 2) * 32'(phase_res_pkg::LSB_MICRO_OHM));
        chk(32'(canon), 32'(prev[6:4] == 3'h0 || prev[3]));
        chk(32'(upd), 32'(expDig(i - 1) != expDig(i - 2)));
        chk(32'(held), expDig(i - 2));
      end
    end
    $display("test_sweep done");
  endtask
  task automatic test_max();
    @(posedge clk);
    @(negedge clk);
    chk(32'(dig), 32'h780);
    chk(32'(belowMin), 32'h0);
    chk(32'(canon), 32'h1);
    @(posedge clk);
    @(negedge clk);
    chk(32'(micro), 32'h780 * 32'(phase_res_pkg::LSB_MICRO_OHM));
    chk(32'(held), 32'h780);
    chk(32'(upd), 32'h0);
    $display("test_max done");
  endtask
  // one reset edge in mid-run clears all, then the held code decodes afresh
  task automatic test_midreset();
    @(posedge clk) rst_b <= 1'b0;
    @(posedge clk) rst_b <= 1'b1;
    @(negedge clk);
    chk(32'(dig), 32'h0);
    chk(32'(micro), 32'h0);
    chk(32'(upd), 32'h0);
    @(negedge clk);
    chk(32'(dig), 32'h780);
    chk(32'(micro), 32'h0);
    chk(32'(upd), 32'h1);
    @(negedge clk);
    chk(32'(micro), 32'h780 * 32'(phase_res_pkg::LSB_MICRO_OHM));
    chk(32'(held), 32'h780);
    $display("test_midreset done");
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    test_reset();
    test_sweep();
    test_max();
    test_midreset();
    wrap_up();
  end
endmodule
`default_nettype wire
